// >>> rsbp_boot_pin_config.v
// reset strap decode: boot source, memory pin routing, wait states, osc range
// Function
// R1 - rom boot at 0x8000 unless code 001
// R2 - memory pin strap sampled at reset
// R3 - unclaimed, unenabled shared pins default to io
// R4 - enabled address pins contiguous from bank pin; the all-io route enables only pins 3-4, and route 3 only pins 2-15
// R5 - 23 address lines, 2 selects, 8/16 data
// R6 - 16-bit: upper bank=half-word, lower bank=a14
// R7 - 8-bit: bank pins are byte bits
// R8 - address pins 15-21 io until software
// R9 - strap codes select pin routing table
// R10 - boot address pins zero to fifteen
// R11 - strap never changes controller internals
// R12 - wait states reset to slowest timing
// R13 - oscillator range strap latched at reset
// R14 - board holds osc strap while running
// R15 - board avoids pin contention by strap
// R16 - boot source code decode map
// R17 - straps held constant until next reset
`timescale 1ns/1ps
`include "rsbp_consts.vh"
module rsbp_boot_pin_config #(
  // R5 address line count
  parameter ADDR_W = `RSBP_ADDR_LINES,
  parameter BOOT_W = `RSBP_BOOT_PINS
) (
  input  wire              ref_clk_i,
  input  wire              reset_i,
  input  wire [2:0]        boot_source_strap_i,
  input  wire [2:0]        ext_mem_pin_strap_i,
  input  wire              osc_range_pin_i,
  input  wire              data_wide_i,
  input  wire              mem_ctrl_enable_i,
  input  wire              pin_a14_sel_i,
  input  wire [6:0]        upper_addr_sel_i,
  input  wire [ADDR_W-1:0] ctrl_addr_i,
  output reg  [31:0]       reset_vector_o,
  output reg  [7:0]        boot_mode_o,
  output reg               ext_boot_o,
  output reg               mem_bank_addr_pin_oe_o,
  output reg  [1:0]        mem_bank_addr_pin_o,
  output reg  [BOOT_W-1:0] boot_pin_is_mem_o,
  output reg  [BOOT_W-1:0] boot_pin_addr_o,
  output reg  [6:0]        mem_addr_pin_hi_en_o,
  output reg  [6:0]        mem_addr_pin_hi_o,
  output reg               mem_data_pin_hi_en_o,
  output reg  [7:0]        setup_cycles_o,
  output reg  [7:0]        strobe_cycles_o,
  output reg  [7:0]        hold_cycles_o,
  output reg               osc_range_strap_o,
  output wire              straps_valid_o
);
  // ==========================================================
  // strap capture
  wire [6:0] strap_w;
  // R2 sample strap
  rsbp_strap_latch #(
    .WIDTH (7)
  ) u_latch (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .strap_i   ({osc_range_pin_i, ext_mem_pin_strap_i, boot_source_strap_i}),
    .strap_o   (strap_w),
    .valid_o   (straps_valid_o)
  );
  wire [2:0] boot_code = strap_w[2:0];
  wire [2:0] pin_code  = strap_w[5:3];
  wire [1:0] route     = pin_code[1:0];
  // ==========================================================
  // boot source and oscillator
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      reset_vector_o    <= `RSBP_ROM_BOOT_VECTOR;
      boot_mode_o       <= 8'h01;
      ext_boot_o        <= 1'b0;
      osc_range_strap_o <= `RSBP_OSC_LOW_RANGE;
    end
    else
    begin
      // R1 vector select
      reset_vector_o <= (boot_code == `RSBP_BOOT_EXT_MEM) ?
                        `RSBP_EXT_BOOT_VECTOR : `RSBP_ROM_BOOT_VECTOR;
      ext_boot_o     <= (boot_code == `RSBP_BOOT_EXT_MEM);
      // R16 one-hot boot mode
      boot_mode_o    <= 8'h01 << boot_code;
      // R13 osc range hold
      osc_range_strap_o <= strap_w[6];
    end
  end
  // ==========================================================
  // wait state reset values, R11 strap not used here
  always @(posedge ref_clk_i)
  begin
    // R12 slowest timing
    if (reset_i || !mem_ctrl_enable_i)
    begin
      setup_cycles_o  <= `RSBP_SETUP_CYCLES;
      strobe_cycles_o <= `RSBP_STROBE_CYCLES;
      hold_cycles_o   <= `RSBP_HOLD_CYCLES;
    end
    else
    begin
      setup_cycles_o  <= setup_cycles_o;
      strobe_cycles_o <= strobe_cycles_o;
      hold_cycles_o   <= hold_cycles_o;
    end
  end
  // ==========================================================
  // pin routing; pin 0 first/a14/ba0, pin 1 ba1, pin 2..15 a1..a14
  reg [BOOT_W-1:0] en_next;
  reg [BOOT_W-1:0] addr_next;
  reg [1:0]        ba_next;
  reg              half_bit;
  integer          i;
  always @*
  begin
    en_next   = {BOOT_W{1'b0}};
    addr_next = {BOOT_W{1'b0}};
    // R6 R7 bank pin mapping
    if (data_wide_i)
    begin
      half_bit = ctrl_addr_i[0];
      ba_next  = {ctrl_addr_i[0], ctrl_addr_i[14]};
    end
    else
    begin
      half_bit = ctrl_addr_i[1];
      ba_next  = ctrl_addr_i[1:0];
    end
    // R9 R10 routing table
    for (i = 2; i < BOOT_W; i = i + 1)
    begin
      addr_next[i] = ctrl_addr_i[i-1];
      // R4 enables pins 2-15 contiguous, except the all-io route, which enables only pins 3-4
      if (route != `RSBP_PIN_ALL_IO)
        en_next[i] = 1'b1;
      else if (i == 3 || i == 4)
        en_next[i] = 1'b1;
    end
    addr_next[1] = half_bit;
    if (route == `RSBP_PIN_FIRST_A14)
    begin
      en_next[1:0]   = 2'h3;
      addr_next[0]   = ctrl_addr_i[14];
    end
    else if (route == `RSBP_PIN_FIRST_BA0)
    begin
      en_next[1:0]   = 2'h3;
      addr_next[0]   = ba_next[0];
    end
  end
  // R3 default io
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      boot_pin_is_mem_o      <= {BOOT_W{1'b0}};
      boot_pin_addr_o        <= {BOOT_W{1'b0}};
      mem_bank_addr_pin_o    <= 2'h0;
      mem_bank_addr_pin_oe_o <= 1'b0;
      mem_addr_pin_hi_en_o   <= 7'h00;
      mem_addr_pin_hi_o      <= 7'h00;
      mem_data_pin_hi_en_o   <= 1'b0;
    end
    else
    begin
      boot_pin_is_mem_o      <= en_next;
      boot_pin_addr_o        <= addr_next;
      mem_bank_addr_pin_o    <= ba_next;
      mem_bank_addr_pin_oe_o <= en_next[1];
      // R8 upper pins by software only
      mem_addr_pin_hi_en_o   <= upper_addr_sel_i & {!data_wide_i ? 1'b0 : 1'b1, 6'h3f};
      mem_addr_pin_hi_o      <= ctrl_addr_i[21:15];
      // R9 wide data bits
      mem_data_pin_hi_en_o   <= pin_code[`RSBP_PIN_WIDE_BIT];
    end
  end
  wire unused_a14 = pin_a14_sel_i;
endmodule // rsbp_boot_pin_config

// >>> rsbp_consts.vh
// constants for the reset strap and boot pin configuration block
`ifndef RSBP_CONSTS_VH
`define RSBP_CONSTS_VH

`define RSBP_ROM_BOOT_VECTOR  32'h0000_8000
`define RSBP_EXT_BOOT_VECTOR  32'h0000_0000
`define RSBP_BOOT_NAND        3'h0
`define RSBP_BOOT_EXT_MEM     3'h1
`define RSBP_BOOT_SD          3'h2
`define RSBP_BOOT_UART        3'h3
`define RSBP_BOOT_USB         3'h4
`define RSBP_BOOT_SPI         3'h5
`define RSBP_BOOT_EMAC        3'h6
`define RSBP_BOOT_HOST        3'h7
`define RSBP_PIN_ALL_IO       2'h0
`define RSBP_PIN_FIRST_A14    2'h1
`define RSBP_PIN_FIRST_BA0    2'h2
`define RSBP_PIN_WIDE_BIT     2
`define RSBP_SETUP_CYCLES     8'h10
`define RSBP_STROBE_CYCLES    8'h40
`define RSBP_HOLD_CYCLES      8'h08
`define RSBP_OSC_LOW_RANGE    1'b0
`define RSBP_OSC_HIGH_RANGE   1'b1
`define RSBP_ADDR_LINES       23
`define RSBP_BOOT_PINS        16
`define RSBP_UPPER_PINS       7
`define RSBP_DATA_HI_PINS     8

`endif

// >>> rsbp_strap_latch.v
// strap capture register held from reset release until the next reset
`timescale 1ns/1ps
module rsbp_strap_latch #(
  parameter WIDTH = 7
) (
  input  wire             ref_clk_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] strap_i,
  output wire [WIDTH-1:0] strap_o,
  output wire             valid_o
);
  reg [WIDTH-1:0] strap_reg;
  reg             held_reg;
  // R17 capture at release
  always @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      held_reg <= 1'b0;
    end
    else if (!held_reg)
    begin
      strap_reg <= strap_i;
      held_reg  <= 1'b1;
    end
  end
  assign strap_o = held_reg ? strap_reg : strap_i;
  assign valid_o = held_reg;
endmodule // rsbp_strap_latch

// >>> rsbp_checker.sv
// strap decode checker
`timescale 1ns/1ps
module rsbp_checker #(
  parameter BOOT_W = 16
) (
  input wire              ref_clk_i,
  input wire              reset_i,
  input wire [2:0]        boot_source_strap_i,
  input wire [2:0]        ext_mem_pin_strap_i,
  input wire              osc_range_pin_i,
  input wire [31:0]       reset_vector_o,
  input wire [7:0]        boot_mode_o,
  input wire [BOOT_W-1:0] boot_pin_is_mem_o,
  input wire [6:0]        mem_addr_pin_hi_en_o,
  input wire              mem_data_pin_hi_en_o,
  input wire [7:0]        setup_cycles_o,
  input wire [7:0]        strobe_cycles_o,
  input wire [7:0]        hold_cycles_o,
  input wire              osc_range_strap_o
);
  reg [6:0] cp_reg;
  reg       got_reg;
  reg       on_reg;
  // ========
  // capture mirror, decode seen one edge later
  always @(posedge ref_clk_i)
  begin
    if (!got_reg) cp_reg <= {boot_source_strap_i, ext_mem_pin_strap_i, osc_range_pin_i};
    got_reg <= !reset_i;
    on_reg  <= got_reg && !reset_i;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_vector_map: assert property (on_reg |-> reset_vector_o ==
    (cp_reg[6:4] == 3'h1 ? 32'h0 : 32'h8000)) else $error("vector");
  a_mode_onehot: assert property (on_reg |-> boot_mode_o == 8'h1 << cp_reg[6:4])
    else $error("mode");
  a_data_high: assert property (on_reg |-> mem_data_pin_hi_en_o == cp_reg[3])
    else $error("data");
  a_wait_slow: assert property (on_reg |->
    {setup_cycles_o, strobe_cycles_o, hold_cycles_o} == 24'h104008) else $error("wait");
  a_osc_latch: assert property (on_reg |-> osc_range_strap_o == cp_reg[0])
    else $error("osc");
  a_addr_contig: assert property (on_reg && cp_reg[2] != cp_reg[1] |->
    &boot_pin_is_mem_o) else $error("addr");
  a_upper_gpio: assert property (on_reg |-> mem_addr_pin_hi_en_o == 7'h0)
    else $error("upper");
  a_held_steady: assert property (on_reg |=> $stable(boot_mode_o) &&
    $stable(boot_pin_is_mem_o)) else $error("held");
endmodule // rsbp_checker

// >>> rsbp_board_model.sv
// board strap model
`timescale 1ns/1ps
module rsbp_board_model (
  input  wire       ref_clk_i,
  input  wire       hold_i,
  input  wire [6:0] pick_i,
  output reg  [6:0] strap_o = 7'h0
);
  always @(posedge ref_clk_i)
    strap_o <= hold_i ? pick_i : {~strap_o[6:1], strap_o[0]};
endmodule // rsbp_board_model

// >>> rsbp_boot_pin_config_tb.sv
// self-checking bench for the strap decode block
`timescale 1ns/1ps
module rsbp_boot_pin_config_tb;
  reg         ref_clk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         hold_i = 1'b1;
  reg  [6:0]  pick_i = 7'h0;
  reg  [25:0] rnd_i = 26'h0;
  reg  [25:0] rnd_prv = 26'h0;
  wire [1:0]  ba_w;
  wire        oe_w;
  wire [6:0]  sp_w, hi_w;
  wire        ext_w, dhi_w, osr_w, ok_w;
  wire [7:0]  mode_w, su_w, st_w, ho_w;
  wire [31:0] vec_w;
  wire [15:0] mem_w;
  integer     fail_count = 0, cmp_count = 0, cyc = 0, i;
  always #2 ref_clk_i = ~ref_clk_i;
  rsbp_board_model brd_u (.ref_clk_i(ref_clk_i), .hold_i(hold_i), .pick_i(pick_i),
    .strap_o(sp_w));
  rsbp_boot_pin_config dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .boot_source_strap_i(sp_w[6:4]), .ext_mem_pin_strap_i(sp_w[3:1]),
    .osc_range_pin_i(sp_w[0]), .data_wide_i(rnd_i[25]), .mem_ctrl_enable_i(rnd_i[24]),
    .pin_a14_sel_i(rnd_i[23]), .upper_addr_sel_i(7'h0), .ctrl_addr_i(rnd_i[22:0]),
    .reset_vector_o(vec_w), .boot_mode_o(mode_w), .ext_boot_o(ext_w),
    .mem_bank_addr_pin_oe_o(oe_w), .mem_bank_addr_pin_o(ba_w), .boot_pin_is_mem_o(mem_w),
    .boot_pin_addr_o(), .mem_addr_pin_hi_en_o(hi_w), .mem_addr_pin_hi_o(),
    .mem_data_pin_hi_en_o(dhi_w), .setup_cycles_o(su_w), .strobe_cycles_o(st_w),
    .hold_cycles_o(ho_w), .osc_range_strap_o(osr_w), .straps_valid_o(ok_w));
  // ========
  // helpers
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  end
  endtask
  task stop_test;
  begin
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  always @(posedge ref_clk_i)
  begin
    rnd_i <= 26'($urandom);
    rnd_prv <= rnd_i;
    cyc = cyc + 1;
    if (cyc == 200)
    begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  // ========
  // one reset per strap code, straps toggled after capture
  initial
  begin
    void'($urandom(32084));
    for (i = 0; i < 8; i = i + 1)
    begin
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      hold_i  <= 1'b1;
      pick_i  <= {i[2:0], i[2:0], i[0]};
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      hold_i <= 1'b0;
      repeat (7) @(posedge ref_clk_i);
      #1;
      chk(vec_w, i == 1 ? 32'h0 : 32'h8000);
      chk({ext_w, mode_w}, {i == 1, 8'h1 << i});
      chk({dhi_w, osr_w, hi_w, ok_w}, {i[2], i[0], 7'h0, 1'b1});
      chk({su_w, st_w, ho_w}, 24'h104008);
      chk(mem_w, i[1:0] == 0 ? 32'h0018 : (i[1] ^ i[0]) ? 32'hffff : 32'hfffc);
      chk({oe_w, ba_w}, {i[1] ^ i[0], rnd_prv[25] ? {rnd_prv[0], rnd_prv[14]} : rnd_prv[1:0]});
      $display("test %0d done", i);
    end
    stop_test;
  end
endmodule // rsbp_boot_pin_config_tb
bind rsbp_boot_pin_config rsbp_checker #(.BOOT_W(BOOT_W)) chk_u (.*);
